// File: hdl/uart_ctl.sv
// Interrupt, FIFO control and line format logic of one UART channel.
// Assumes the FIFO/shifter datapath supplies events synchronous to clk;
// a second channel instantiates this module again.
// Contract
// - Receive interrupt follows trigger level crossing.
// - Data ready set on push, clears empty.
// - All enables clear gives polled mode.
// - Line status bits report polled status.
// - Receive interrupt: character or trigger level.
// - Transmit interrupt on empty, also on enable.
// - Overrun immediate, errors at read head.
// - Modem deltas raise modem interrupt.
// - Time-out after four chars plus twelve bits.
// - Status reads clear their interrupts.
// - Transmit interrupt cleared by identification read, write.
// - Identification encodes highest priority source.
// - Only highest pending reported, rest queued.
// - Bit zero low while interrupt pending.
// - Bits seven, six show FIFO enable.
// - Queue enable gates other control bits.
// - FIFO reset bits pulse, self clear.
// - DMA mode selects receive ready pin behaviour.
// - Trigger select gives 1, 4, 8, 14.
// - Word length five to eight bits.
// - Stop bits one, one-and-half, or two.
// - Interrupt pin driven only with output two.
`include "uart_ctl_regs.svh"
module uart_ctl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic [7:0] rx_data,
  input wire uart_ctl_pkg::rx_evt_t rx_evt,
  input wire uart_ctl_pkg::tx_stat_t tx_stat,
  input wire logic [3:0] modem_delta,
  input wire logic [3:0] modem_in,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic thr_write,
  output logic rhr_read,
  output logic [1:0] word_len,
  output logic stop_two,
  output logic stop_half,
  output logic [7:0] line_format_q,
  output logic [7:0] modem_control_q,
  output logic receive_ready_n,
  output logic transmit_ready_n,
  output logic irq_o,
  output logic irq_oe_n,
  output logic general_output_two_n
);
  import uart_ctl_pkg::*;

  logic [7:0] ien_r, lfmt_r, mctl_r, scr_r;
  logic qen_r, dma_r;
  logic [1:0] trig_sel_r;
  logic rxrst_r, txrst_r;
  logic dr_r, oe_r, ls_int_r, tx_int_r, ms_int_r, to_int_r;
  logic tx_empty_d_r, txen_d_r;
  logic [7:0] rdata_r;
  logic [9:0] to_cnt_r;
  to_state_t to_st_r;
  logic [4:0] trig;
  logic rx_int, head_err_int, ls_pend, ms_pend, any_pend;
  logic [3:0] iid;
  logic dlab, rd_hold, rd_iid, rd_ls, rd_ms, wr_hold, wr_qc;
  logic [9:0] to_len;

  // Trigger level lookup, used for the interrupt and the ready pin.
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: trig_level = `TRIG_L0;
      2'b01: trig_level = `TRIG_L1;
      2'b10: trig_level = `TRIG_L2;
      2'b11: trig_level = `TRIG_L3;
    endcase
  endfunction

  // Address decode; the divisor latch shares offsets 0 and 1 with dlab.
  assign dlab = lfmt_r[`LF_DLAB];
  assign rd_hold = rd && addr == `ADR_HOLD && !dlab;
  assign wr_hold = wr && addr == `ADR_HOLD && !dlab;
  assign rd_iid = rd && addr == `ADR_IID;
  assign rd_ls = rd && addr == `ADR_LSTAT;
  assign rd_ms = rd && addr == `ADR_MSTAT;
  assign wr_qc = wr && addr == `ADR_IID;
  assign thr_write = wr_hold;
  assign rhr_read = rd_hold;

  // Plain control registers; each channel instance holds its own copy.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ien_r <= `IEN_RST;
      lfmt_r <= `LF_RST;
      mctl_r <= `MC_RST;
      scr_r <= 8'h00;
    end else if (wr) begin
      if (addr == `ADR_IEN && !dlab) ien_r <= {4'h0, wdata[3:0]};
      if (addr == `ADR_LFMT) lfmt_r <= wdata;
      if (addr == `ADR_MCTL) mctl_r <= {3'h0, wdata[4:0]};
      if (addr == `ADR_SCR) scr_r <= wdata;
    end
  end

  // Queue control: other bits only take effect with the enable set.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qen_r <= 1'b0;
      dma_r <= 1'b0;
      trig_sel_r <= 2'b00;
      rxrst_r <= 1'b0;
      txrst_r <= 1'b0;
    end else begin
      rxrst_r <= 1'b0;
      txrst_r <= 1'b0;
      if (wr_qc) begin
        qen_r <= wdata[`QC_EN];
        if (wdata[`QC_EN]) begin
          dma_r <= wdata[`QC_DMA];
          trig_sel_r <= wdata[7:6];
          rxrst_r <= wdata[`QC_RXRST];
          txrst_r <= wdata[`QC_TXRST];
        end
      end
    end
  end
  assign rx_fifo_reset = rxrst_r;
  assign tx_fifo_reset = txrst_r;

  // Line format decode for the shifters.
  assign word_len = lfmt_r[1:0];
  assign stop_two = lfmt_r[`LF_STOP] && lfmt_r[1:0] != 2'b00;
  assign stop_half = lfmt_r[`LF_STOP] && lfmt_r[1:0] == 2'b00;
  assign line_format_q = lfmt_r;
  assign modem_control_q = mctl_r;

  // Data ready and overrun; a push in the clearing cycle wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dr_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      if (rx_evt.push) dr_r <= 1'b1;
      else if (rx_evt.level == 5'h00 || rxrst_r) dr_r <= 1'b0;
      if (rx_evt.overrun) oe_r <= 1'b1;
      else if (rd_ls) oe_r <= 1'b0;
    end
  end

  // Line status interrupt latch; a new error beats the clearing read.
  assign head_err_int = rx_evt.head_err && dr_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ls_int_r <= 1'b0;
    else if (rx_evt.overrun || head_err_int) ls_int_r <= 1'b1;
    else if (rd_ls) ls_int_r <= 1'b0;
  end
  assign ls_pend = ien_r[`IEN_LS] && (ls_int_r || oe_r);

  // Receive data interrupt: level-based, clears below the trigger.
  assign trig = qen_r ? trig_level(trig_sel_r) : 5'h01;
  assign rx_int = ien_r[`IEN_RX] && rx_evt.level >= trig;

  // Transmit ready: edge into empty, or enable rising while empty.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_int_r <= 1'b0;
      tx_empty_d_r <= 1'b1;
      txen_d_r <= 1'b0;
    end else begin
      tx_empty_d_r <= tx_stat.fifo_empty;
      txen_d_r <= ien_r[`IEN_TX];
      if ((tx_stat.fifo_empty && !tx_empty_d_r) ||
          (ien_r[`IEN_TX] && !txen_d_r && tx_stat.fifo_empty))
        tx_int_r <= 1'b1;
      else if (wr_hold || (rd_iid && iid == `IID_TX))
        tx_int_r <= 1'b0;
    end
  end

  // Modem delta bits are held in the status register outside.
  assign ms_pend = ien_r[`IEN_MS] && |modem_delta;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ms_int_r <= 1'b0;
    else ms_int_r <= ms_pend && !rd_ms;
  end

  // Time-out timer counts bit ticks; a character is counted as ten ticks.
  assign to_len = 10'(`TO_CHARS * 10 + `TO_BITS);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      to_st_r <= TO_IDLE;
      to_cnt_r <= 10'h000;
      to_int_r <= 1'b0;
    end else begin
      unique case (to_st_r)
        TO_IDLE: begin
          to_cnt_r <= 10'h000;
          if (qen_r && ien_r[`IEN_RX] && dr_r) to_st_r <= TO_RUN;
        end
        TO_RUN: begin
          if (rx_evt.push || rd_hold || !dr_r) to_cnt_r <= 10'h000;
          else if (rx_evt.bit_tick) to_cnt_r <= to_cnt_r + 10'h001;
          if (!dr_r || !qen_r) to_st_r <= TO_IDLE;
          else if (to_cnt_r >= to_len) begin
            to_int_r <= 1'b1;
            to_st_r <= TO_FIRE;
          end
        end
        TO_FIRE: begin
          if (rd_hold || !qen_r) begin
            to_int_r <= 1'b0;
            to_st_r <= TO_IDLE;
          end
        end
        default: to_st_r <= TO_IDLE;
      endcase
    end
  end

  // Priority encoder: only the top pending source is shown.
  always_comb begin
    if (ls_pend) iid = `IID_LS;
    else if (to_int_r && ien_r[`IEN_RX]) iid = `IID_TO;
    else if (rx_int) iid = `IID_RX;
    else if (tx_int_r && ien_r[`IEN_TX]) iid = `IID_TX;
    else if (ms_int_r) iid = `IID_MS;
    else iid = `IID_NONE;
  end
  assign any_pend = iid != `IID_NONE;

  // Read mux, registered; with all enables clear this is polled mode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdata_r <= 8'h00;
    else if (rd) begin
      unique case (addr)
        `ADR_HOLD: rdata_r <= rx_data;
        `ADR_IEN: rdata_r <= ien_r;
        `ADR_IID: rdata_r <= {{2{qen_r}}, 2'b00, iid};
        `ADR_LFMT: rdata_r <= lfmt_r;
        `ADR_MCTL: rdata_r <= mctl_r;
        `ADR_LSTAT: rdata_r <= {rx_evt.any_err && qen_r,
                                tx_stat.fifo_empty && tx_stat.shifter_empty,
                                tx_stat.fifo_empty,
                                rx_evt.head_err && dr_r ? 3'h7 : 3'h0,
                                oe_r, dr_r};
        `ADR_MSTAT: rdata_r <= {modem_in, modem_delta};
        `ADR_SCR: rdata_r <= scr_r;
      endcase
    end
  end
  assign rdata = rdata_r;

  // Interrupt pin is driven only while the output-two bit is set.
  assign irq_o = any_pend;
  assign irq_oe_n = !mctl_r[`MC_OUT2];
  assign general_output_two_n = !mctl_r[`MC_OUT2];

  // DMA mode asserts receive ready only at or above trigger; transmit ready follows empty in both modes.
  assign receive_ready_n = dma_r ? !(rx_evt.level >= trig) : !dr_r;
  assign transmit_ready_n = dma_r ? !tx_stat.fifo_empty
                                  : !tx_stat.fifo_empty;
endmodule

// File: shared/uart_ctl_regs.svh
// Register addresses, field positions, reset values and timing counts
// for the UART channel control block.
// Assumes a 3-bit byte address bus with the documented map.
`ifndef UART_CTL_REGS_SVH
`define UART_CTL_REGS_SVH
`define ADR_HOLD 3'h0
`define ADR_IEN 3'h1
`define ADR_IID 3'h2
`define ADR_LFMT 3'h3
`define ADR_MCTL 3'h4
`define ADR_LSTAT 3'h5
`define ADR_MSTAT 3'h6
`define ADR_SCR 3'h7
`define IEN_RX 0
`define IEN_TX 1
`define IEN_LS 2
`define IEN_MS 3
`define QC_EN 0
`define QC_RXRST 1
`define QC_TXRST 2
`define QC_DMA 3
`define LF_STOP 2
`define LF_DLAB 7
`define MC_OUT2 3
`define IID_LS 4'h6
`define IID_TO 4'hc
`define IID_RX 4'h4
`define IID_TX 4'h2
`define IID_MS 4'h0
`define IID_NONE 4'h1
`define IEN_RST 8'h00
`define LF_RST 8'h00
`define MC_RST 8'h00
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0e
`define TO_CHARS 4
`define TO_BITS 12
`endif

// File: shared/uart_ctl_pkg.sv
// Types shared by the UART channel control block and its bench.
// Assumes nothing beyond the register header.
package uart_ctl_pkg;
  // Receive side events from the shifter and FIFO datapath.
  typedef struct packed {
    logic push;
    logic overrun;
    logic [4:0] level;
    logic head_err;
    logic any_err;
    logic char_tick;
    logic bit_tick;
  } rx_evt_t;
  // Transmit side status from the transmit datapath.
  typedef struct packed {
    logic fifo_empty;
    logic shifter_empty;
  } tx_stat_t;
  typedef enum logic [1:0] {
    TO_IDLE = 2'b00,
    TO_RUN = 2'b01,
    TO_FIRE = 2'b10
  } to_state_t;
endpackage

// File: sim/uart_ctl_checker.sv
// Port-level checks for the UART channel control block.
// Assumes it is bound to uart_ctl and sees only that module's ports.
module uart_ctl_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset,
  input wire logic thr_write,
  input wire logic [1:0] word_len,
  input wire logic stop_two,
  input wire logic stop_half,
  input wire logic [7:0] line_format_q,
  input wire logic [7:0] modem_control_q,
  input wire logic irq_o,
  input wire logic irq_oe_n,
  input wire logic general_output_two_n
);
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Queue control write with the enable bit set.
  wire qc = wr && addr == 3'h2 && wdata[0];
  a_rx_reset_pulse: assert property (
    qc && wdata[1] |=> rx_fifo_reset ##1 !rx_fifo_reset) else $error("rx rst");
  a_tx_reset_pulse: assert property (
    qc && wdata[2] |=> tx_fifo_reset ##1 !tx_fifo_reset) else $error("tx rst");
  a_queue_gated: assert property (
    wr && addr == 3'h2 && !wdata[0] |=> !rx_fifo_reset && !tx_fifo_reset)
    else $error("gated reset");
  a_irq_pin_enable: assert property (
    irq_oe_n == !modem_control_q[3] && general_output_two_n == irq_oe_n)
    else $error("irq pin enable");
  a_iid_pending: assert property (
    rd && addr == 3'h2 |=> rdata[0] == !$past(irq_o)) else $error("iid bit0");
  a_word_length: assert property (
    word_len == line_format_q[1:0]) else $error("word length");
  a_stop_bits: assert property (
    stop_half == (line_format_q[2] && word_len == 2'h0) &&
    stop_two == (line_format_q[2] && word_len != 2'h0)) else $error("stop");
  a_thr_strobe: assert property (
    wr && addr == 3'h0 && !line_format_q[7] |-> thr_write) else $error("thr");
  c_rx_reset: cover property (rx_fifo_reset);
  c_iid_pending: cover property (rd && addr == 3'h2 && irq_o);
  c_thr_write: cover property (thr_write);
endmodule
bind uart_ctl uart_ctl_checker u_chk (.*);

// File: sim/uart_dp_model.sv
// Behavioural FIFO datapath on the far side of the control block.
// Assumes the bench pulses push and ovr for single clock cycles.
module uart_dp_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic ovr,
  input wire logic rhr_read,
  input wire logic thr_write,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset,
  input wire logic tick,
  output uart_ctl_pkg::rx_evt_t rx_evt,
  output uart_ctl_pkg::tx_stat_t tx_stat,
  output logic [7:0] rx_data
);
  import uart_ctl_pkg::*;
  logic [4:0] level_r;
  logic tx_empty_r;
  // Level counts pushes less host reads; a queue reset clears the level to zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) level_r <= 5'h00;
    else if (rx_fifo_reset) level_r <= 5'h00;
    else level_r <= level_r + 5'(push) - 5'(rhr_read && level_r != 5'h00);
  end
  // The transmit queue fills on a host write and empties on a reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tx_empty_r <= 1'b1;
    else if (tx_fifo_reset) tx_empty_r <= 1'b1;
    else if (thr_write) tx_empty_r <= 1'b0;
  end
  // Errors stay idle, the bench paces bit ticks; the head shows the level.
  assign rx_evt = {push, ovr, level_r, 3'h0, tick};
  assign tx_stat = {tx_empty_r, tx_empty_r};
  assign rx_data = {3'h0, level_r};
endmodule

// File: sim/testbench.sv
// Self-checking bench driving the control block's register port.
// Assumes the datapath model stands on the far side of the block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_ctl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic push = 1'b0, ovr = 1'b0, tick = 1'b0;
  logic irq, rxr_n, txr_n, st2, sth;
  logic [1:0] wl;
  logic [7:0] mcq, lfq, exp_v;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, rx_data;
  logic [3:0] delta = 4'h0;
  logic rhr_read, thr_write, rxr, txr, oe_n, op2_n;
  rx_evt_t rx_evt;
  tx_stat_t tx_stat;
  int miscompares = 0, cmp_count = 0;
  uart_ctl u_uart_ctl (.clk, .sys_rst, .addr, .rd, .wr, .wdata, .rdata,
    .rx_data, .rx_evt, .tx_stat, .modem_delta(delta), .modem_in(4'h0),
    .rx_fifo_reset(rxr), .tx_fifo_reset(txr), .thr_write, .rhr_read,
    .word_len(wl), .stop_two(st2), .stop_half(sth), .line_format_q(lfq),
    .modem_control_q(mcq), .receive_ready_n(rxr_n),
    .transmit_ready_n(txr_n), .irq_o(irq), .irq_oe_n(oe_n),
    .general_output_two_n(op2_n));
  uart_dp_model u_uart_dp_model (.clk, .sys_rst, .push, .ovr, .rhr_read,
    .thr_write, .rx_fifo_reset(rxr), .tx_fifo_reset(txr), .tick, .rx_evt,
    .tx_stat, .rx_data);
  task automatic chk(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes rise after an edge, are taken at the next, then drop.
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stands until the next read, so take it one edge later.
    @(posedge clk);
    chk($sformatf("reg %0h", a), rdata, exp);
  endtask
  // An overrun pulse stands alone, since an overrun byte is never stored.
  task automatic rx_char(input int n, input logic ov);
    repeat (n) begin
      @(posedge clk);
      push <= !ov;
      ovr <= ov;
      @(posedge clk);
      push <= 1'b0;
      ovr <= 1'b0;
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  localparam logic [4:0] TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  initial forever #12.5 clk = ~clk;
  // A hang is cut short well inside the cycle budget.
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rreg(3'h1, 8'h00);
    rreg(3'h2, 8'h01);
    rreg(3'h3, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wreg(3'h3, 8'(i));
      rreg(3'h3, 8'(i));
      chk("fmt out", lfq, 8'(i));
      chk("word len", {6'h00, wl}, 8'(i % 4));
      exp_v = {6'h00, i[2] && i[1:0] == 2'h0, i[2] && i[1:0] != 2'h0};
      chk("stop bits", {6'h00, sth, st2}, exp_v);
    end
    wreg(3'h2, 8'hc6);
    rreg(3'h2, 8'h01);
    wreg(3'h1, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wreg(3'h2, {2'(t), 6'h03});
      rx_char(int'(TRIG[t]) - 1, 1'b0);
      rreg(3'h2, 8'hc1);
      rreg(3'h5, {7'h30, TRIG[t] != 5'h01});
      rx_char(1, 1'b0);
      rreg(3'h2, 8'hc4);
    end
    rreg(3'h0, 8'h0e);
    rreg(3'h2, 8'hc1);
    wreg(3'h1, 8'h02);
    rreg(3'h2, 8'hc2);
    rreg(3'h2, 8'hc1);
    wreg(3'h1, 8'h08);
    delta <= 4'h4;
    rreg(3'h2, 8'hc0);
    rreg(3'h6, 8'h04);
    delta <= 4'h0;
    rreg(3'h2, 8'hc1);
    wreg(3'h1, 8'h0f);
    rx_char(1, 1'b0);
    rx_char(1, 1'b1);
    rreg(3'h2, 8'hc6);
    chk("irq out", {7'h00, irq}, 8'h01);
    rreg(3'h5, 8'h63);
    rreg(3'h2, 8'hc4);
    rreg(3'h0, 8'h0e);
    rreg(3'h2, 8'hc2);
    wreg(3'h0, 8'h55);
    rreg(3'h2, 8'hc1);
    // Bit ticks with no new character run the time-out down.
    tick <= 1'b1;
    repeat (60) @(posedge clk);
    tick <= 1'b0;
    rreg(3'h2, 8'hcc);
    rreg(3'h0, 8'h0d);
    rreg(3'h2, 8'hc1);
    wreg(3'h2, 8'hc5);
    // The emptied queue reaches the interrupt two edges after the pulse.
    @(posedge clk);
    rreg(3'h2, 8'hc2);
    chk("ready pins", {6'h00, rxr_n, txr_n}, 8'h00);
    wreg(3'h2, 8'hc9);
    @(posedge clk);
    chk("ready dma", {6'h00, rxr_n, txr_n}, 8'h02);
    wreg(3'h4, 8'h08);
    rreg(3'h4, 8'h08);
    chk("irq pin", {6'h00, oe_n, op2_n}, 8'h00);
    chk("modem ctl", mcq, 8'h08);
    chk("irq out", {7'h00, irq}, 8'h00);
    give_verdict();
  end
endmodule
